// ==== shared/alu_consts.svh ====
// How it works
// - Add-with-carry on accumulator: acc gets acc plus carry.
// - Add-with-carry on memory: memory byte gets memory plus carry, written back.
// - Subtract immediate: acc gets acc minus immediate.
// - Subtract memory from acc: acc gets acc minus memory; memory untouched.
// - Subtract acc from memory: memory gets memory minus acc.
// - Every subtraction adds the one's complement of the subtrahend plus the inverted borrow.
// - Subtract with borrow into acc: acc minus memory minus carry.
// - Subtract with borrow into memory: memory minus acc minus carry.
// - Subtract carry from acc alone: acc minus carry.
// - Every operation here updates zero, carry, half-carry and overflow flags.
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define ALU_W         8
`define ALU_NIB       4
`define ACC_RST       8'h00
`define FLG_RST       4'h0
`define OP_W          4
`define OP_NOP        4'h0
`define OP_ADDC_A     4'h1
`define OP_ADDC_M     4'h2
`define OP_SUB_AI     4'h3
`define OP_SUB_AM     4'h4
`define OP_SUB_MA     4'h5
`define OP_SUBC_AM    4'h6
`define OP_SUBC_MA    4'h7
`define OP_SUBC_A     4'h8
`define OP_ADD_AI     4'h9
`define OP_ADD_AM     4'ha
`define OP_ADD_MA     4'hb
`define OP_ADDC_AM    4'hc
`define OP_ADDC_MA    4'hd
`define REG_CTRL      12'h000
`define REG_OPERAND   12'h004
`define REG_ACC       12'h008
`define REG_MEM       12'h00c
`define REG_FLAGS     12'h010
`define REG_STATUS    12'h014
`define FLG_Z         0
`define FLG_C         1
`define FLG_AC        2
`define FLG_OV        3
`endif

// ==== shared/alu_pkg.sv ====
package alu_pkg;
    typedef struct packed {
        logic       zero;
        logic       ovf;
        logic       half;
        logic       carry;
    } flags_t;
    typedef struct packed {
        logic [7:0] res;
        flags_t     flg;
        logic       to_mem;
    } alu_out_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_WRITE = 3'b100
    } state_t;
endpackage

// ==== hw/alu_core.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_core
    import alu_pkg::*;
(
    // Operation
    input  wire logic [`OP_W-1:0]  op,
    input  wire logic [`ALU_W-1:0] acc,
    input  wire logic [`ALU_W-1:0] mem,
    input  wire logic [`ALU_W-1:0] imm,
    input  wire logic              cin,
    // Result
    output alu_out_t               out
);
    logic [`ALU_W-1:0] lhs;
    logic [`ALU_W-1:0] rhs;
    logic              sub;
    logic              usec;
    logic              to_mem;
    logic [`ALU_W-1:0] rhs_x;
    logic              cin_x;
    logic [`ALU_W:0]   sum;
    logic [`ALU_NIB:0] nsum;
    logic              c7;
    logic              c3;

    always_comb
    begin
        lhs    = acc;
        rhs    = '0;
        sub    = 1'b0;
        usec   = 1'b0;
        to_mem = 1'b0;
        case (op)
            `OP_ADDC_A:  begin usec = 1'b1; end
            `OP_ADDC_M:  begin lhs = mem; usec = 1'b1; to_mem = 1'b1; end
            `OP_SUB_AI:  begin rhs = imm; sub = 1'b1; end
            `OP_SUB_AM:  begin rhs = mem; sub = 1'b1; end
            `OP_SUB_MA:  begin lhs = mem; rhs = acc; sub = 1'b1; to_mem = 1'b1; end
            `OP_SUBC_AM: begin rhs = mem; sub = 1'b1; usec = 1'b1; end
            `OP_SUBC_MA: begin lhs = mem; rhs = acc; sub = 1'b1; usec = 1'b1; to_mem = 1'b1; end
            `OP_SUBC_A:  begin sub = 1'b1; usec = 1'b1; end
            `OP_ADD_AI:  begin rhs = imm; end
            `OP_ADD_AM:  begin rhs = mem; end
            `OP_ADD_MA:  begin rhs = mem; to_mem = 1'b1; end
            `OP_ADDC_AM: begin rhs = mem; usec = 1'b1; end
            `OP_ADDC_MA: begin rhs = mem; usec = 1'b1; to_mem = 1'b1; end
            default:     begin lhs = acc; end
        endcase
    end

    // Subtract: lhs + ~rhs + 1 - c, i.e. carry-in is the inverted borrow
    always_comb
    begin
        rhs_x = sub ? ~rhs : rhs;
        cin_x = sub ? ~(usec & cin) : (usec & cin);
        sum   = {1'b0, lhs} + {1'b0, rhs_x} + {{`ALU_W{1'b0}}, cin_x};
        nsum  = {1'b0, lhs[`ALU_NIB-1:0]} + {1'b0, rhs_x[`ALU_NIB-1:0]} + {{`ALU_NIB{1'b0}}, cin_x};
        c7    = sum[`ALU_W];
        c3    = nsum[`ALU_NIB];
        out.res        = sum[`ALU_W-1:0];
        out.to_mem     = to_mem;
        out.flg.zero   = (sum[`ALU_W-1:0] == `ACC_RST);
        out.flg.carry  = sub ? ~c7 : c7;
        out.flg.half   = sub ? ~c3 : c3;
        out.flg.ovf    = (lhs[`ALU_W-1] == rhs_x[`ALU_W-1]) && (sum[`ALU_W-1] != lhs[`ALU_W-1]);
    end
endmodule

// ==== hw/alu_top.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_top
    import alu_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    logic [`ALU_W-1:0] acc_r;
    logic [`ALU_W-1:0] mem_r;
    logic [`ALU_W-1:0] imm_r;
    logic [`OP_W-1:0]  op_r;
    flags_t            flg_r;
    state_t            state_r;
    state_t            state_nxt;
    logic              done_r;
    alu_out_t          res_r;
    alu_out_t          alu_o;
    logic              wr;
    logic              rd;
    logic              hit;
    logic [31:0]       rdata;

    assign wr = PSEL & PENABLE & PWRITE & ~PREADY;
    assign rd = PSEL & PENABLE & ~PWRITE & ~PREADY;

    alu_core u_core
    (
        .op  (op_r),
        .acc (acc_r),
        .mem (mem_r),
        .imm (imm_r),
        .cin (flg_r.carry),
        .out (alu_o)
    );

    always_comb
    begin
        hit = 1'b1;
        case (PADDR)
            `REG_CTRL:    rdata = {28'h000_0000, op_r};
            `REG_OPERAND: rdata = {24'h00_0000, imm_r};
            `REG_ACC:     rdata = {24'h00_0000, acc_r};
            `REG_MEM:     rdata = {24'h00_0000, mem_r};
            `REG_FLAGS:   rdata = {28'h000_0000, flg_r.ovf, flg_r.half, flg_r.carry, flg_r.zero};
            `REG_STATUS:  rdata = {30'h000_0000, done_r, (state_r != ST_IDLE)};
            default:
            begin
                rdata = 32'h0000_0000;
                hit   = 1'b0;
            end
        endcase
    end

    // One wait state: PREADY rises the cycle after PENABLE
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PRDATA  <= rd ? rdata : 32'h0000_0000;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit;
        end
    end

    always_comb
    begin
        case (state_r)
            ST_IDLE:  state_nxt = (wr && PADDR == `REG_CTRL) ? ST_EXEC : ST_IDLE;
            ST_EXEC:  state_nxt = ST_WRITE;
            ST_WRITE: state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            res_r <= '0;
        else if (state_r == ST_EXEC)
            res_r <= alu_o;
    end

    // Operands writable only while idle
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            op_r  <= `OP_NOP;
            imm_r <= `ACC_RST;
        end
        else if (wr && state_r == ST_IDLE)
        begin
            if (PADDR == `REG_CTRL)
                op_r <= PWDATA[`OP_W-1:0];
            if (PADDR == `REG_OPERAND)
                imm_r <= PWDATA[`ALU_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            acc_r <= `ACC_RST;
            mem_r <= `ACC_RST;
        end
        else if (state_r == ST_WRITE)
        begin
            if (res_r.to_mem)
                mem_r <= res_r.res;
            else
                acc_r <= res_r.res;
        end
        else if (wr && state_r == ST_IDLE)
        begin
            if (PADDR == `REG_ACC)
                acc_r <= PWDATA[`ALU_W-1:0];
            if (PADDR == `REG_MEM)
                mem_r <= PWDATA[`ALU_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            flg_r <= `FLG_RST;
        else if (state_r == ST_WRITE && op_r != `OP_NOP)
            flg_r <= res_r.flg;
        else if (wr && state_r == ST_IDLE && PADDR == `REG_FLAGS)
            flg_r <= {PWDATA[`FLG_Z], PWDATA[`FLG_OV], PWDATA[`FLG_AC], PWDATA[`FLG_C]};
    end

    // Done sets on completion; a new start clears it, completion wins
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            done_r <= 1'b0;
        else if (state_r == ST_WRITE)
            done_r <= 1'b1;
        else if (state_nxt == ST_EXEC)
            done_r <= 1'b0;
    end
endmodule

// ==== verification/alu_top_sva.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_top_sva (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE;
    endsequence
    AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !PREADY ##1 PREADY)
        else $error("ready not after exactly one wait");
    AST_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_CAUSE: assert property (PREADY |-> $past(PSEL && PENABLE, 1))
        else $error("ready without access");
    AST_ERR_MAP: assert property (PREADY |-> PSLVERR == (PADDR > `REG_STATUS || PADDR[1:0] != 2'b00))
        else $error("slave error does not match address map");
    AST_ERR_ONLY: assert property (PSLVERR |-> PREADY)
        else $error("slave error outside ready");
    AST_IDLE_DATA: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside ready");
    AST_WR_DATA: assert property (PREADY && PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("read data on write");
    AST_BYTE: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_ERR_DATA: assert property (PSLVERR |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
bind alu_top alu_top_sva alu_top_sva_inst (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// ==== verification/alu_top_tb.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_top_tb;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    int          mismatches = 0;
    int          checks_done = 0;
    int          seed = 32'h5bf40834;
    logic [7:0]  cv [4] = '{8'h00, 8'h80, 8'hff, 8'h7f};
    alu_top alu_top_inst (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            $display("unexpected pready expected 1 seen %b", pready);
            mismatches++;
        end
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Reference: result in [11:4], flags OV AC C Z in [3:0], memory destination in [12]
    function automatic logic [12:0] model(input logic [3:0] op, input logic [7:0] a, m, i, input logic c);
        logic [7:0] l;
        logic [7:0] r;
        logic       ci;
        logic       sb;
        logic       tm;
        logic [8:0] s;
        logic [4:0] h;
        sb = op inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
        tm = op inside {4'h2, 4'h5, 4'h7, 4'hb, 4'hd};
        l = tm ? m : a;
        r = (op inside {4'h0, 4'h1, 4'h2, 4'h8, 4'he, 4'hf}) ? 8'h00 : (op inside {4'h3, 4'h9}) ? i : (tm ? a : m);
        ci = (op inside {4'h1, 4'h2, 4'hc, 4'hd}) ? c : (op inside {4'h6, 4'h7, 4'h8}) ? ~c : sb;
        if (sb)
            r = ~r;
        s = l + r + ci;
        h = l[3:0] + r[3:0] + ci;
        return {tm, s[7:0], (l[7] == r[7]) && (s[7] != l[7]), h[4] ^ sb, s[8] ^ sb, s[7:0] == 8'h00};
    endfunction
    task automatic run(input logic [3:0] op, input logic [7:0] a, m, i, input logic c);
        logic [12:0] e;
        logic [31:0] d;
        logic        er;
        int          n;
        logic [31:0] rv;
        e = model(op, a, m, i, c);
        if (op == `OP_NOP)
            e[3:0] = {2'b00, c, 1'b0};
        rv = $random(seed);
        apb(1, `REG_ACC, {rv[23:0], a}, d, er);
        apb(1, `REG_MEM, {24'h00_0000, m}, d, er);
        apb(1, `REG_OPERAND, {24'h00_0000, i}, d, er);
        apb(1, `REG_FLAGS, {30'h0000_0000, c, 1'b0}, d, er);
        apb(1, `REG_CTRL, {28'h000_0000, op}, d, er);
        n = 0;
        do
        begin
            apb(0, `REG_STATUS, 0, d, er);
            n++;
        end
        while (d[1:0] !== 2'b10 && n < 10);
        chk("status", 32'h0000_0002, d);
        apb(0, `REG_ACC, 0, d, er);
        chk("acc", {24'h00_0000, e[12] ? a : e[11:4]}, d);
        apb(0, `REG_MEM, 0, d, er);
        chk("mem", {24'h00_0000, e[12] ? e[11:4] : m}, d);
        apb(0, `REG_FLAGS, 0, d, er);
        chk("flags", {28'h000_0000, e[3:0]}, d);
    endtask
    initial
    begin
        logic [31:0] d;
        logic        er;
        logic [31:0] r0;
        logic [31:0] r1;
        logic [31:0] r2;
        logic [31:0] r3;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        apb(0, `REG_STATUS, 0, d, er);
        chk("reset status", 32'h0000_0000, d);
        apb(0, `REG_FLAGS, 0, d, er);
        chk("reset flags", 32'h0000_0000, d);
        for (int op = 0; op < 16; op++)
        begin
            for (int k = 0; k < 8; k++)
                if (k < 4)
                    run(op[3:0], cv[k], cv[3 - k], cv[k ^ 1], k[0]);
                else
                begin
                    r0 = $random(seed);
                    r1 = $random(seed);
                    r2 = $random(seed);
                    r3 = $random(seed);
                    run(op[3:0], r0[7:0], r1[7:0], r2[7:0], r3[0]);
                end
        end
        // Second reset in mid-run clears the accumulator again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, `REG_ACC, 0, d, er);
        chk("acc after reset", 32'h0000_0000, d);
        apb(0, `REG_FLAGS, 0, d, er);
        chk("flags after reset", 32'h0000_0000, d);
        apb(0, 12'h018, 0, d, er);
        chk("unmapped error", 32'h0000_0001, {31'h000_0000, er});
        chk("unmapped data", 32'h0000_0000, d);
        test_done();
    end
    initial
    begin
        #(25 * 40000);
        mismatches++;
        test_done();
    end
endmodule
